// file: cdd_clock_dist.v
// Functional notes
// - select 00 is external input via prescaler, 10 is oscillator via prescaler
// - select 01 is external input without prescaler; 11 illegal, true outputs held low, complements high
// - channel direct-route bit sends prescaler input to that channel's output pair
// - total division is prescaler ratio times channel division
// - prescaler divides by 2 to 6 from a three-bit field
// - channel divider divides 2 to 32; divide by one only by bypass
// - bypass passes input undivided and parks the divider counter
// - count register: low count upper nibble, high count lower nibble
// - output high N+1 input cycles, low M+1, period N+M+2
// - divider counts whichever clock reaches its input
// - correction on after reset; per-channel disable bit turns it off
// - correction off: duty is (N+1)/(N+M+2)
// - correction restores 50 percent duty at divider output
// - direct oscillator gives 50 percent; direct external keeps its own duty
// - raw external source with bypass passes input unchanged
`timescale 1ns/1ps
`default_nettype none
`include "cdd_defines.vh"

module cdd_clock_dist (
  input  wire        aclk,          // system clock, 40 MHz
  input  wire        aresetn,       // synchronous reset, active low
  input  wire [13:0] s_axi_awaddr,  // write address
  input  wire        s_axi_awvalid, // write address valid
  output reg         s_axi_awready, // write address ready
  input  wire [31:0] s_axi_wdata,   // write data
  input  wire [3:0]  s_axi_wstrb,   // write byte enables
  input  wire        s_axi_wvalid,  // write data valid
  output reg         s_axi_wready,  // write data ready
  output reg  [1:0]  s_axi_bresp,   // write response
  output reg         s_axi_bvalid,  // write response valid
  input  wire        s_axi_bready,  // write response ready
  input  wire [13:0] s_axi_araddr,  // read address
  input  wire        s_axi_arvalid, // read address valid
  output reg         s_axi_arready, // read address ready
  output reg  [31:0] s_axi_rdata,   // read data
  output reg  [1:0]  s_axi_rresp,   // read response
  output reg         s_axi_rvalid,  // read data valid
  input  wire        s_axi_rready,  // read data ready
  input  wire        osc_in,        // internal oscillator level
  input  wire        ext_clk_in,    // external clock input level
  output reg         hs_output_a,   // channel 0 true
  output reg         hs_output_b,   // channel 0 complement
  output reg         hs_output_c,   // channel 1 true
  output reg         hs_output_d    // channel 1 complement
);

  // ==========================================================
  // register decode
  // ==========================================================
  localparam [3:0] SEL_NONE = 4'hF;

  // decode shared by read and write paths
  function [3:0] cdd_dec;
    input [13:0] addr;
    begin
      if (addr == `CDD_ADDR_CH0_CNT) cdd_dec = 4'h0;
      else if (addr == `CDD_ADDR_CH0_BYP) cdd_dec = 4'h1;
      else if (addr == `CDD_ADDR_CH0_RC) cdd_dec = 4'h2;
      else if (addr == `CDD_ADDR_CH1_CNT) cdd_dec = 4'h3;
      else if (addr == `CDD_ADDR_CH1_BYP) cdd_dec = 4'h4;
      else if (addr == `CDD_ADDR_CH1_RC) cdd_dec = 4'h5;
      else if (addr == `CDD_ADDR_PRESC) cdd_dec = 4'h6;
      else if (addr == `CDD_ADDR_SRCSEL) cdd_dec = 4'h7;
      else if (addr == `CDD_ADDR_STATUS) cdd_dec = 4'h8;
      else cdd_dec = SEL_NONE;
    end
  endfunction

  reg  [7:0]  cnt_q [0:1];
  reg  [7:0]  byp_q [0:1];
  reg  [7:0]  rc_q  [0:1];
  reg  [7:0]  presc_q;
  reg  [7:0]  srcsel_q;
  reg  [13:0] aw_addr_q;
  reg         aw_have_q;
  reg  [31:0] w_data_q;
  reg         w_strb0_q;
  reg         w_have_q;
  wire        wr_fire;
  wire [3:0]  wr_sel;
  reg  [4:0]  status_w;
  wire [1:0]  ch_out;
  reg         presc_out_q;
  reg         div_in_q;
  reg         illegal_q;

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_sel  = cdd_dec(aw_addr_q);

  // ==========================================================
  // axi write channel
  // ==========================================================
  // address and data are taken in either order; one write in flight
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CDD_RESP_OKAY;
      aw_addr_q     <= 14'h0000;
      aw_have_q     <= 1'b0;
      w_data_q      <= 32'h00000000;
      w_strb0_q     <= 1'b0;
      w_have_q      <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (!aw_have_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb0_q    <= s_axi_wstrb[0];
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (!w_have_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == SEL_NONE) ? `CDD_RESP_SLVERR : `CDD_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // setup registers; only the low byte lane carries data
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q[0] <= `CDD_RST_CNT;
      cnt_q[1] <= `CDD_RST_CNT;
      byp_q[0] <= `CDD_RST_BYP;
      byp_q[1] <= `CDD_RST_BYP;
      rc_q[0]  <= `CDD_RST_RC;
      rc_q[1]  <= `CDD_RST_RC;
      presc_q  <= `CDD_RST_PRESC;
      srcsel_q <= `CDD_RST_SRCSEL;
    end else if (wr_fire && w_strb0_q) begin
      if (wr_sel == 4'h0) cnt_q[0] <= w_data_q[7:0];
      else if (wr_sel == 4'h1) byp_q[0] <= w_data_q[7:0];
      else if (wr_sel == 4'h2) rc_q[0] <= w_data_q[7:0];
      else if (wr_sel == 4'h3) cnt_q[1] <= w_data_q[7:0];
      else if (wr_sel == 4'h4) byp_q[1] <= w_data_q[7:0];
      else if (wr_sel == 4'h5) rc_q[1] <= w_data_q[7:0];
      else if (wr_sel == 4'h6) presc_q <= {5'h00, w_data_q[2:0]};
      else if (wr_sel == 4'h7) srcsel_q <= {6'h00, w_data_q[1:0]};
    end
  end

  // ==========================================================
  // axi read channel
  // ==========================================================
  always @* begin
    status_w = {illegal_q, ch_out, presc_out_q, div_in_q};
  end

  // answer lands one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CDD_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `CDD_RESP_OKAY;
        case (cdd_dec(s_axi_araddr))
          4'h0: s_axi_rdata <= {24'h000000, cnt_q[0]};
          4'h1: s_axi_rdata <= {24'h000000, byp_q[0]};
          4'h2: s_axi_rdata <= {24'h000000, rc_q[0]};
          4'h3: s_axi_rdata <= {24'h000000, cnt_q[1]};
          4'h4: s_axi_rdata <= {24'h000000, byp_q[1]};
          4'h5: s_axi_rdata <= {24'h000000, rc_q[1]};
          4'h6: s_axi_rdata <= {24'h000000, presc_q};
          4'h7: s_axi_rdata <= {24'h000000, srcsel_q};
          4'h8: s_axi_rdata <= {27'h0000000, status_w};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CDD_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // source synchronisers and selection
  // ==========================================================
  // clocks arrive as sampled levels; three stages so edge logic never sees stage one
  reg  [2:0] osc_sync_q;
  reg  [2:0] ext_sync_q;
  wire [1:0] sel;
  wire       src_lvl;
  wire       src_prev;
  wire       src_edge;
  wire       src_rise;
  wire       div_in_w;
  wire       div_edge;
  wire       div_rise;

  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_sync_q <= 3'h0;
      ext_sync_q <= 3'h0;
    end else begin
      osc_sync_q <= {osc_sync_q[1:0], osc_in};
      ext_sync_q <= {ext_sync_q[1:0], ext_clk_in};
    end
  end

  assign sel      = srcsel_q[`CDD_SRC_MSB:0];
  // prescaler input: oscillator for 10, external clock otherwise
  assign src_lvl  = (sel == `CDD_SRC_OSC_PRE) ? osc_sync_q[1] : ext_sync_q[1];
  assign src_prev = (sel == `CDD_SRC_OSC_PRE) ? osc_sync_q[2] : ext_sync_q[2];
  assign src_edge = src_lvl ^ src_prev;
  assign src_rise = src_lvl & ~src_prev;

  // ==========================================================
  // prescaler
  // ==========================================================
  // counts half periods so odd ratios still give a 50 percent output
  reg  [2:0] ratio_w;
  reg  [3:0] pcnt_q;
  reg        prun_q;
  wire [3:0] pend;

  always @* begin
    ratio_w = presc_q[`CDD_PRESC_MSB:0];
    if (ratio_w < 3'h2 || ratio_w > 3'h6) ratio_w = 3'h2;
  end

  assign pend = {ratio_w, 1'b0} - 4'h1;

  always @(posedge aclk) begin
    if (!aresetn) begin
      pcnt_q      <= 4'h0;
      prun_q      <= 1'b0;
      presc_out_q <= 1'b0;
    end else if (sel == `CDD_SRC_EXT_RAW || sel == `CDD_SRC_ILLEGAL) begin
      pcnt_q      <= 4'h0;
      prun_q      <= 1'b0;
      presc_out_q <= 1'b0;
    end else if (!prun_q) begin
      if (src_rise) begin
        prun_q      <= 1'b1;
        pcnt_q      <= 4'h0;
        presc_out_q <= 1'b1;
      end
    end else if (src_edge) begin
      // high for ratio half periods of each pair, period is ratio cycles
      if (pcnt_q >= pend) begin
        pcnt_q      <= 4'h0;
        presc_out_q <= 1'b1;
      end else begin
        pcnt_q      <= pcnt_q + 4'h1;
        presc_out_q <= ((pcnt_q + 4'h1) < {1'b0, ratio_w});
      end
    end
  end

  // divider input: prescaler output or raw external clock
  assign div_in_w = (sel == `CDD_SRC_EXT_RAW) ? ext_sync_q[2] : presc_out_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      div_in_q  <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      div_in_q  <= div_in_w;
      illegal_q <= (sel == `CDD_SRC_ILLEGAL);
    end
  end

  assign div_edge = div_in_w ^ div_in_q;
  assign div_rise = div_in_w & ~div_in_q;

  // ==========================================================
  // channel dividers
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
      wire [3:0] n_w;
      wire [3:0] m_w;
      wire [5:0] d_w;
      wire [6:0] hi_w;
      wire [6:0] end_w;
      wire       dcc_w;
      reg  [6:0] hcnt_q;
      reg        run_q;
      reg        cnt_out_q;
      reg        out_q;

      assign n_w   = cnt_q[g][`CDD_HIGH_MSB:`CDD_HIGH_LSB];
      assign m_w   = cnt_q[g][`CDD_LOW_MSB:`CDD_LOW_LSB];
      assign d_w   = {2'h0, n_w} + {2'h0, m_w} + 6'h02;
      assign dcc_w = ~rc_q[g][`CDD_CORRECTION_DISABLE_BIT];
      // correction holds high for d half periods; otherwise n+1 full cycles
      assign hi_w  = dcc_w ? {1'b0, d_w}
                           : ({2'h0, n_w, 1'b0} + 7'h02);
      assign end_w = {d_w, 1'b0} - 7'h01;

      // bypass parks the counter, standing in for the powered-down divider
      always @(posedge aclk) begin
        if (!aresetn) begin
          hcnt_q    <= 7'h00;
          run_q     <= 1'b0;
          cnt_out_q <= 1'b0;
        end else if (byp_q[g][`CDD_BYP_BIT] || illegal_q) begin
          hcnt_q    <= 7'h00;
          run_q     <= 1'b0;
          cnt_out_q <= 1'b0;
        end else if (!run_q) begin
          if (div_rise) begin
            run_q     <= 1'b1;
            hcnt_q    <= 7'h00;
            cnt_out_q <= 1'b1;
          end
        end else if (div_edge) begin
          if (hcnt_q >= end_w) begin
            hcnt_q    <= 7'h00;
            cnt_out_q <= 1'b1;
          end else begin
            hcnt_q    <= hcnt_q + 7'h01;
            cnt_out_q <= ((hcnt_q + 7'h01) < hi_w);
          end
        end
      end

      // output mux: direct route, bypass, or divided clock; illegal source holds low
      always @(posedge aclk) begin
        if (!aresetn) begin
          out_q <= 1'b0;
        end else if (illegal_q) begin
          out_q <= 1'b0;
        end else if (rc_q[g][`CDD_ROUTE_BIT]) begin
          out_q <= src_prev;
        end else if (byp_q[g][`CDD_BYP_BIT]) begin
          out_q <= div_in_q;
        end else begin
          out_q <= cnt_out_q;
        end
      end

      assign ch_out[g] = out_q;
    end
  endgenerate

  // ==========================================================
  // output pairs
  // ==========================================================
  // one more stage so each pin leaves a flip-flop with its complement aligned
  always @(posedge aclk) begin
    if (!aresetn) begin
      hs_output_a <= 1'b0;
      hs_output_b <= 1'b1;
      hs_output_c <= 1'b0;
      hs_output_d <= 1'b1;
    end else begin
      hs_output_a <= ch_out[0];
      hs_output_b <= ~ch_out[0];
      hs_output_c <= ch_out[1];
      hs_output_d <= ~ch_out[1];
    end
  end

endmodule // cdd_clock_dist
`default_nettype wire

// file: cdd_clock_dist_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// bus and output pair checker
module cdd_clock_dist_chk (
  input wire logic        aclk,          // clock
  input wire logic        aresetn,       // reset, low
  input wire logic        s_axi_awvalid, // aw valid
  input wire logic        s_axi_awready, // aw ready
  input wire logic        s_axi_wvalid,  // w valid
  input wire logic        s_axi_wready,  // w ready
  input wire logic        s_axi_bvalid,  // b valid
  input wire logic        s_axi_bready,  // b ready
  input wire logic        s_axi_arvalid, // ar valid
  input wire logic        s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata,   // r data
  input wire logic        s_axi_rvalid,  // r valid
  input wire logic        s_axi_rready,  // r ready
  input wire logic        hs_output_a,   // ch0 true
  input wire logic        hs_output_b,   // ch0 compl
  input wire logic        hs_output_c,   // ch1 true
  input wire logic        hs_output_d    // ch1 compl
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // pairs stay complementary, so a consumer never sees both legs equal
  property p_pair0; hs_output_b == !hs_output_a; endproperty
  a_pair0: assert property (p_pair0) else $error("ch0 pair legs equal");
  property p_pair1; hs_output_d == !hs_output_c; endproperty
  a_pair1: assert property (p_pair1) else $error("ch1 pair legs equal");
  // registers are one byte wide
  property p_rbyte; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  a_rbyte: assert property (p_rbyte) else $error("read data above byte");
  property p_rtake; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rtake: assert property (p_rtake) else $error("read answer late");
  property p_rfall; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready;
  endproperty
  a_rfall: assert property (p_rfall) else $error("read not closed");
  // address and data sit one edge in capture flops, so the answer comes an edge later
  property p_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
      (!s_axi_bvalid && !s_axi_awready) ##1 s_axi_bvalid;
  endproperty
  a_wtake: assert property (p_wtake) else $error("write answer wrong");
  // both readies return one edge after the response leaves
  property p_bfall;
    s_axi_bvalid && s_axi_bready |=> (!s_axi_bvalid && !s_axi_awready) ##1
      (s_axi_awready && s_axi_wready);
  endproperty
  a_bfall: assert property (p_bfall) else $error("write not closed");
  property p_bblock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_bblock: assert property (p_bblock) else $error("write taken early");
  property p_rblock; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rblock: assert property (p_rblock) else $error("read taken early");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_ch1: cover property ($rose(hs_output_c));
endmodule // cdd_clock_dist_chk
bind cdd_clock_dist cdd_clock_dist_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .hs_output_a(hs_output_a), .hs_output_b(hs_output_b), .hs_output_c(hs_output_c),
  .hs_output_d(hs_output_d));
`default_nettype wire

// file: cdd_clock_sink.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// downstream consumer: measures a channel in aclk cycles
module cdd_clock_sink (
  input  wire logic        aclk,     // sample clock
  input  wire logic        aresetn,  // reset, low
  input  wire logic        clk_in,   // channel seen
  output var  logic [15:0] period_q, // rise to rise
  output var  logic [15:0] high_q    // rise to fall
);
  logic        prev_q;
  logic [15:0] cnt_q;
  // one aclk resolution is enough, the sources are far slower than aclk
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
      cnt_q <= 16'h0000;
      period_q <= 16'h0000;
      high_q <= 16'h0000;
    end else begin
      prev_q <= clk_in;
      cnt_q <= cnt_q + 16'h0001;
      if (clk_in && !prev_q) begin
        period_q <= cnt_q;
        cnt_q <= 16'h0001;
      end
      if (!clk_in && prev_q)
        high_q <= cnt_q;
    end
  end
endmodule // cdd_clock_sink
`default_nettype wire

// file: cdd_defines.vh
`ifndef CDD_DEFINES_VH
`define CDD_DEFINES_VH

// register indices; byte address is four times the index
`define CDD_IDX_CH0_CNT   12'h190
`define CDD_IDX_CH0_BYP   12'h191
`define CDD_IDX_CH0_RC    12'h192
`define CDD_IDX_CH1_CNT   12'h196
`define CDD_IDX_CH1_BYP   12'h197
`define CDD_IDX_CH1_RC    12'h198
`define CDD_IDX_PRESC     12'h1E0
`define CDD_IDX_SRCSEL    12'h1E1
`define CDD_IDX_STATUS    12'h1F0

// byte addresses on the bus
`define CDD_ADDR_CH0_CNT  14'h0640
`define CDD_ADDR_CH0_BYP  14'h0644
`define CDD_ADDR_CH0_RC   14'h0648
`define CDD_ADDR_CH1_CNT  14'h0658
`define CDD_ADDR_CH1_BYP  14'h065C
`define CDD_ADDR_CH1_RC   14'h0660
`define CDD_ADDR_PRESC    14'h0780
`define CDD_ADDR_SRCSEL   14'h0784
`define CDD_ADDR_STATUS   14'h07C0

// field positions
`define CDD_LOW_MSB       7
`define CDD_LOW_LSB       4
`define CDD_HIGH_MSB      3
`define CDD_HIGH_LSB      0
`define CDD_BYP_BIT       7
`define CDD_ROUTE_BIT     1
`define CDD_CORRECTION_DISABLE_BIT    0
`define CDD_PRESC_MSB     2
`define CDD_SRC_MSB       1

// source select encodings
`define CDD_SRC_EXT_PRE   2'h0
`define CDD_SRC_EXT_RAW   2'h1
`define CDD_SRC_OSC_PRE   2'h2
`define CDD_SRC_ILLEGAL   2'h3

// reset values
`define CDD_RST_CNT       8'h00
`define CDD_RST_BYP       8'h00
`define CDD_RST_RC        8'h00
`define CDD_RST_PRESC     8'h02
`define CDD_RST_SRCSEL    8'h02

// axi responses
`define CDD_RESP_OKAY     2'h0
`define CDD_RESP_SLVERR   2'h2

`endif

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdd_defines.vh"
// ==========
// bench top
module tb_top;
  logic        aclk, aresetn, osc_in, ext_clk_in, hs_output_a, hs_output_b;
  logic        hs_output_c, hs_output_d, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb, ph_q;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [15:0] p0, h0, p1, h1;
  logic [13:0] ra [8];
  logic [7:0]  rv [8];
  int          errors, checks, cyc, i;
  cdd_clock_dist uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .osc_in(osc_in),
    .ext_clk_in(ext_clk_in), .hs_output_a(hs_output_a), .hs_output_b(hs_output_b),
    .hs_output_c(hs_output_c), .hs_output_d(hs_output_d));
  cdd_clock_sink u_sink0 (.aclk(aclk), .aresetn(aresetn), .clk_in(hs_output_a),
    .period_q(p0), .high_q(h0));
  cdd_clock_sink u_sink1 (.aclk(aclk), .aresetn(aresetn), .clk_in(hs_output_c),
    .period_q(p1), .high_q(h1));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // sources: oscillator period 4, external period 6 with 2 high, so duty shows
  always @(posedge aclk) begin
    ph_q <= (ph_q == 4'hB) ? 4'h0 : ph_q + 4'h1;
    osc_in <= ph_q[1];
    ext_clk_in <= (ph_q % 6) < 2;
  end
  // hang guard, the tests need about 6200 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s: %0h not %0h", $time, msg, seen, exp);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] v);
    bit aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [13:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // settle long enough for two periods of the slowest setting
  task automatic clk_chk(input bit ch, input int p, input int h);
    repeat (600) @(posedge aclk);
    chk(ch ? p1 : p0, p, "period");
    if (h != 0)
      chk(ch ? h1 : h0, h, "high time");
  endtask
  task test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    aresetn = 1'b0;
    ph_q = 4'h0;
    osc_in = 1'b0;
    ext_clk_in = 1'b0;
    s_axi_awaddr = 14'h0000;
    s_axi_araddr = 14'h0000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    ra = '{`CDD_ADDR_CH0_CNT, `CDD_ADDR_CH0_BYP, `CDD_ADDR_CH0_RC, `CDD_ADDR_CH1_CNT,
      `CDD_ADDR_CH1_BYP, `CDD_ADDR_CH1_RC, `CDD_ADDR_PRESC, `CDD_ADDR_SRCSEL};
    rv = '{`CDD_RST_CNT, `CDD_RST_BYP, `CDD_RST_RC, `CDD_RST_CNT, `CDD_RST_BYP,
      `CDD_RST_RC, `CDD_RST_PRESC, `CDD_RST_SRCSEL};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd(ra[i]);
      chk(d, {24'h000000, rv[i]}, "reset value");
    end
    rd(14'h0000);
    chk(r, `CDD_RESP_SLVERR, "unmapped read");
    wr(14'h0004, 8'h5A);
    chk(r, `CDD_RESP_SLVERR, "unmapped write");
    $display("test registers done");
    // divide by 3 then 5, correction off: 4*3*5 period, high 2 of 5
    wr(`CDD_ADDR_PRESC, 8'h03);
    chk(r, `CDD_RESP_OKAY, "mapped write");
    wr(`CDD_ADDR_CH0_CNT, 8'h21);
    wr(`CDD_ADDR_CH0_RC, 8'h01);
    rd(`CDD_ADDR_CH0_CNT);
    chk(d, 32'h00000021, "count readback");
    clk_chk(0, 60, 24);
    clk_chk(1, 24, 12);
    wr(`CDD_ADDR_CH0_RC, 8'h00);
    clk_chk(0, 60, 30);
    wr(`CDD_ADDR_PRESC, 8'h02);
    wr(`CDD_ADDR_CH0_CNT, 8'hFF);
    clk_chk(0, 256, 128);
    $display("test division done");
    wr(`CDD_ADDR_CH0_BYP, 8'h80);
    clk_chk(0, 8, 4);
    wr(`CDD_ADDR_SRCSEL, 8'h01);
    clk_chk(0, 6, 2);
    clk_chk(1, 12, 0);
    $display("test bypass done");
    wr(`CDD_ADDR_SRCSEL, 8'h00);
    wr(`CDD_ADDR_CH1_RC, 8'h02);
    clk_chk(1, 6, 2);
    clk_chk(0, 12, 0);
    wr(`CDD_ADDR_SRCSEL, 8'h02);
    clk_chk(1, 4, 2);
    $display("test direct route done");
    wr(`CDD_ADDR_SRCSEL, 8'h03);
    repeat (100) @(posedge aclk);
    chk({hs_output_c, hs_output_a}, 32'h0, "illegal select");
    // status: only the illegal flag stands, prescaler and dividers parked low
    rd(`CDD_ADDR_STATUS);
    chk(d, 32'h00000010, "illegal status");
    $display("test illegal select done");
    test_done();
  end
endmodule // tb_top
`default_nettype wire
